// >>> logic/adcc_pkg.sv
/*
 * Constants for the converter control and result register block:
 * APB offsets, register field positions, reset values, source codes
 * and conversion timing.
 * Assumes a single APB slave at 20 MHz; offsets are byte addresses.
 */
package adcc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RES_LOW = 8'h00; // Result low byte
    localparam logic [7:0] ADDR_RES_HIGH = 8'h04; // Result high byte
    localparam logic [7:0] ADDR_CTRL0 = 8'h08; // Control 0
    localparam logic [7:0] ADDR_CTRL1 = 8'h0C; // Control 1
    localparam logic [7:0] ADDR_TSENS = 8'h10; // Temp sensor control
    localparam logic [7:0] ADDR_BGAP = 8'h14; // Bandgap control
    localparam logic [7:0] ADDR_REFT_HIGH = 8'h18; // Reference temp high
    localparam logic [7:0] ADDR_REFT_LOW = 8'h1C; // Reference temp low
    localparam logic [7:0] ADDR_IRQ = 8'h20; // Done flag and enable
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int START_BIT = 7; // Start strobe in control 0
    localparam int BUSY_BIT = 6; // Busy flag in control 0
    localparam int ENABLE_BIT = 5; // Converter enable
    localparam int JUSTIFY_BIT = 4; // Result justification
    localparam int TEMP_SENSOR_ENABLE_BIT = 0; // Temp sensor enable
    localparam int TRSV_BIT = 1; // Reserved temp bit
    localparam int BGEN_BIT = 0; // Bandgap enable
    localparam int IRQ_FLAG_BIT = 0; // Done flag
    localparam int IRQ_EN_BIT = 1; // Done request enable
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL0_RST = 8'h00; // Control 0 reset
    localparam logic [7:0] CTRL1_RST = 8'h00; // Control 1 reset
    localparam logic [1:0] TSENS_RST = 2'h2; // Reserved bit reads 1
    localparam logic [11:0] REFT_VALUE = 12'h800; // Arbitrary trim value
    // ------------------------------------------------------------
    // Source codes and channel limits
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_EXT = 3'h0; // External channel
    localparam logic [2:0] SRC_BGAP = 3'h1; // Bandgap
    localparam logic [2:0] SRC_TEMP = 3'h2; // Temperature sensor
    localparam logic [2:0] SRC_AMPO = 3'h3; // Amplifier output
    localparam logic [2:0] SRC_AMPP = 3'h4; // Amplifier positive input
    localparam logic [2:0] SRC_FORBID = 3'h7; // Never stored
    localparam int EXT_CHANNELS = 8; // External inputs
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [4:0] CONV_TICKS = 5'h10; // Divided clocks per conversion
    localparam int DIV_W = 7; // Prescaler width, up to /128
endpackage : adcc_pkg

// >>> logic/adcc_divider.sv
/*
 * Converter clock prescaler: one-cycle tick every 2**sel system clocks.
 * Assumes sel is stable except between conversions.
 */
`timescale 1ns/100ps
`default_nettype none
module adcc_divider (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic run, // Count only while converting
    input wire logic [2:0] sel, // Divide code
    output logic tick // Divided clock enable pulse
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [adcc_pkg::DIV_W-1:0] cnt; // Prescaler count
        logic tick; // Registered tick
    } adcc_div_state_t;
    adcc_div_state_t s_q, s_d;
    logic [adcc_pkg::DIV_W-1:0] mask; // Count mask for code

    // Next state; terminal count chosen by mask
    always_comb begin
        mask = adcc_pkg::DIV_W'((8'h01 << sel) - 8'h01);
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = '0; // Restart phase every conversion
        end else if ((s_q.cnt & mask) == mask) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    // Register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule : adcc_divider
`default_nettype wire

// >>> logic/adcc_top.sv
/*
 * Converter control and result registers behind an APB slave.
 * Starts a conversion on the high-then-low write of the start bit,
 * counts divided clocks, captures the sample and packs the result.
 * Assumes conv_sample is a settled converter output on pclk.
 */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module adcc_top (
    input wire logic pclk, // System clock, 20 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [11:0] conv_sample, // Converter output word
    output logic converter_enable, // Powers analog core
    output logic [7:0] ext_analog_inputs, // One-hot channel switches
    output logic [4:0] int_source_onehot, // Bgap,temp,ampo,ampp,ext
    output logic [1:0] reference_sel, // Reference choice
    output logic bandgap_enable, // Bandgap output on
    output logic temp_sensor_enable, // Temp sensor on
    output logic conv_done_irq // Done request, level
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01, // Waiting for start
        ST_CONV = 2'b10 // Converting
    } adcc_st_t;

    typedef struct packed {
        adcc_st_t st; // Sequencer state
        logic start; // Start bit as written
        logic enable; // Converter enable
        logic justify; // Justification select
        logic [3:0] chan; // ext_channel_sel
        logic [2:0] src; // input_source_sel
        logic [1:0] vref; // reference_sel
        logic [2:0] ckdiv; // conv_clock_div_sel
        logic [1:0] tsens; // Reserved and temp enable
        logic bgap; // bandgap_enable
        logic [11:0] result; // Last result word
        logic [4:0] ticks; // Divided clocks left
        logic done; // Done flag, sticky
        logic done_en; // Done request enable
        logic [31:0] prdata; // Read data
        logic pready; // Ready
        logic pslverr; // Error
        logic [7:0] ext_sw; // Channel switches
        logic [4:0] src_oh; // Source switches
        logic irq; // Request output
    } adcc_state_t;

    adcc_state_t s_q, s_d;
    logic div_tick; // Divided clock enable
    logic wr_acc; // Write access phase
    logic rd_acc; // Read access phase
    logic start_fall; // Start written high to low
    logic conv_end; // Last divided clock

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pack result into high/low byte per justification
    function automatic logic [15:0] pack_result(input logic [11:0] r,
                                                input logic j);
        if (j) begin
            pack_result = {4'h0, r};
        end else begin
            pack_result = {r, 4'h0};
        end
    endfunction : pack_result

    // Data register read helper, narrower fields zero above
    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h00_0000, b};
    endfunction : byte_word

    logic [15:0] res_packed; // Packed result pair
    logic [15:0] reft_packed; // Packed reference pair
    assign res_packed = pack_result(s_q.result, s_q.justify);
    assign reft_packed = {adcc_pkg::REFT_VALUE, 4'h0};

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    adcc_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(s_q.st == ST_CONV),
        .sel(s_q.ckdiv),
        .tick(div_tick)
    );

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign start_fall = wr_acc && (paddr == adcc_pkg::ADDR_CTRL0)
        && s_q.start && !pwdata[adcc_pkg::START_BIT];
    assign conv_end = (s_q.st == ST_CONV) && div_tick
        && (s_q.ticks == 5'h01);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // Register writes take effect in the access phase
        if (wr_acc && !s_q.pready) begin
            case (paddr)
                adcc_pkg::ADDR_CTRL0: begin
                    // Busy bit not written
                    s_d.start = pwdata[adcc_pkg::START_BIT];
                    s_d.enable = pwdata[adcc_pkg::ENABLE_BIT];
                    s_d.justify = pwdata[adcc_pkg::JUSTIFY_BIT];
                    s_d.chan = pwdata[3:0];
                end
                adcc_pkg::ADDR_CTRL1: begin
                    // Forbidden source code keeps prior value
                    if (pwdata[7:5] != adcc_pkg::SRC_FORBID) begin
                        s_d.src = pwdata[7:5];
                    end
                    s_d.vref = pwdata[4:3];
                    s_d.ckdiv = pwdata[2:0];
                end
                adcc_pkg::ADDR_TSENS: begin
                    s_d.tsens = pwdata[1:0];
                end
                adcc_pkg::ADDR_BGAP: begin
                    s_d.bgap = pwdata[adcc_pkg::BGEN_BIT];
                end
                adcc_pkg::ADDR_IRQ: begin
                    s_d.done_en = pwdata[adcc_pkg::IRQ_EN_BIT];
                    // Write one clears the done flag
                    if (pwdata[adcc_pkg::IRQ_FLAG_BIT]) begin
                        s_d.done = 1'b0;
                    end
                end
                adcc_pkg::ADDR_RES_LOW, adcc_pkg::ADDR_RES_HIGH,
                adcc_pkg::ADDR_REFT_HIGH, adcc_pkg::ADDR_REFT_LOW: begin
                    s_d.pslverr = 1'b0; // Read-only, write ignored
                end
                default: begin
                    s_d.pslverr = 1'b1; // Unmapped
                end
            endcase
        end
        // Read mux
        if (rd_acc && !s_q.pready) begin
            case (paddr)
                adcc_pkg::ADDR_RES_LOW: s_d.prdata = byte_word(res_packed[7:0]);
                adcc_pkg::ADDR_RES_HIGH:
                    s_d.prdata = byte_word(res_packed[15:8]);
                adcc_pkg::ADDR_CTRL0: s_d.prdata = byte_word({s_q.start,
                    s_q.st == ST_CONV, s_q.enable, s_q.justify, s_q.chan});
                adcc_pkg::ADDR_CTRL1: s_d.prdata = byte_word({s_q.src,
                    s_q.vref, s_q.ckdiv});
                adcc_pkg::ADDR_TSENS: s_d.prdata = byte_word({6'h00, s_q.tsens});
                adcc_pkg::ADDR_BGAP: s_d.prdata = byte_word({7'h00, s_q.bgap});
                adcc_pkg::ADDR_REFT_HIGH:
                    s_d.prdata = byte_word(reft_packed[15:8]);
                adcc_pkg::ADDR_REFT_LOW:
                    s_d.prdata = byte_word(reft_packed[7:0]);
                adcc_pkg::ADDR_IRQ: s_d.prdata = byte_word({6'h00,
                    s_q.done_en, s_q.done});
                default: begin
                    s_d.prdata = 32'h0000_0000;
                    s_d.pslverr = 1'b1; // Unmapped
                end
            endcase
        end
        // One wait state: answer in the cycle after the access phase
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
        end
        // Sequencer
        case (s_q.st)
            ST_IDLE: begin
                // Start only when powered; busy blocks restarts
                if (start_fall && s_q.enable) begin
                    s_d.st = ST_CONV;
                    s_d.ticks = adcc_pkg::CONV_TICKS;
                end
            end
            ST_CONV: begin
                if (!s_q.enable) begin
                    s_d.st = ST_IDLE; // Powered off: abort, keep result
                end else if (div_tick) begin
                    s_d.ticks = s_q.ticks - 5'h01;
                    if (conv_end) begin
                        s_d.st = ST_IDLE;
                        s_d.result = conv_sample;
                        s_d.done = 1'b1; // Set wins over clear
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Analog switch controls
        s_d.src_oh = 5'h00;
        s_d.ext_sw = 8'h00;
        case (s_q.src)
            adcc_pkg::SRC_BGAP: s_d.src_oh[0] = 1'b1;
            adcc_pkg::SRC_TEMP: s_d.src_oh[1] = 1'b1;
            adcc_pkg::SRC_AMPO: s_d.src_oh[2] = 1'b1;
            adcc_pkg::SRC_AMPP: s_d.src_oh[3] = 1'b1;
            default: s_d.src_oh[4] = 1'b1; // External path
        endcase
        // Channel switch closes regardless of source; software parks it
        if (!s_q.chan[3]) begin
            s_d.ext_sw[s_q.chan[2:0]] = 1'b1;
        end
        s_d.irq = s_d.done && s_d.done_en;
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.tsens <= adcc_pkg::TSENS_RST;
            s_q.src_oh <= 5'h10;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign converter_enable = s_q.enable;
    assign ext_analog_inputs = s_q.ext_sw;
    assign int_source_onehot = s_q.src_oh;
    assign reference_sel = s_q.vref;
    assign bandgap_enable = s_q.bgap;
    assign temp_sensor_enable = s_q.tsens[adcc_pkg::TEMP_SENSOR_ENABLE_BIT];
    assign conv_done_irq = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_busy_set;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_IDLE && start_fall && s_q.enable)
            |=> s_q.st == ST_CONV;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("no busy");
    property p_busy_clear;
        @(posedge pclk) disable iff (!presetn)
        conv_end && s_q.enable |=> s_q.st == ST_IDLE && s_q.done;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");
    property p_ignore;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_CONV && !conv_end && s_q.enable)
            |=> s_q.st == ST_CONV;
    endproperty
    a_ignore: assert property (p_ignore) else $error("busy dropped");
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !s_q.enable |=> $stable(s_q.result);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_just0;
        @(posedge pclk) disable iff (!presetn)
        !s_q.justify |-> res_packed[3:0] == 4'h0;
    endproperty
    a_just0: assert property (p_just0) else $error("low nibble");
    property p_just1;
        @(posedge pclk) disable iff (!presetn)
        s_q.justify |-> res_packed[15:12] == 4'h0;
    endproperty
    a_just1: assert property (p_just1) else $error("high nibble");
    property p_nochan;
        @(posedge pclk) disable iff (!presetn)
        s_q.chan[3] ##1 1'b1 |-> ext_analog_inputs == 8'h00;
    endproperty
    a_nochan: assert property (p_nochan) else $error("float");
    property p_forbid;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> s_q.src != adcc_pkg::SRC_FORBID;
    endproperty
    a_forbid: assert property (p_forbid) else $error("code 111");
    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    // Power, read-only busy, capture, count and switch checks
    property p_off;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_IDLE && start_fall && !s_q.enable)
            |=> s_q.st == ST_IDLE;
    endproperty
    a_off: assert property (p_off) else $error("started off");
    property p_ro;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_IDLE && !start_fall) |=> s_q.st == ST_IDLE;
    endproperty
    a_ro: assert property (p_ro) else $error("busy written");
    property p_cap;
        @(posedge pclk) disable iff (!presetn)
        conv_end && s_q.enable |=> s_q.result == $past(conv_sample);
    endproperty
    a_cap: assert property (p_cap) else $error("no capture");
    property p_tick;
        @(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_CONV && s_q.enable && div_tick)
            |=> s_q.ticks == $past(s_q.ticks) - 5'h01;
    endproperty
    a_tick: assert property (p_tick) else $error("bad count");
    property p_div;
        @(posedge pclk) disable iff (!presetn)
        div_tick && s_q.ckdiv != 3'h0 |=> !div_tick;
    endproperty
    a_div: assert property (p_div) else $error("tick too fast");
    // Presetn in the antecedent skips the release edge itself
    property p_chan;
        @(posedge pclk) disable iff (!presetn)
        presetn && !s_q.chan[3]
            |=> ext_analog_inputs == (8'h01 << $past(s_q.chan[2:0]));
    endproperty
    a_chan: assert property (p_chan) else $error("wrong switch");
    property p_src;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> $onehot(int_source_onehot);
    endproperty
    a_src: assert property (p_src) else $error("source mix");
    c_conv: cover property (@(posedge pclk) conv_end);
    c_ign: cover property (@(posedge pclk) start_fall && s_q.st == ST_CONV);
    c_irq: cover property (@(posedge pclk) conv_done_irq);
    c_off: cover property (@(posedge pclk) start_fall && !s_q.enable);
endmodule : adcc_top
`default_nettype wire

// >>> verif/adcc_top_tb.sv
/*
 * Self-checking bench for adcc_top: register access over APB, start
 * pulse, busy flag, result packing, selects and the done request.
 * Assumes adcc_pkg and adcc_top are compiled first; no far-side model.
 */
`timescale 1ns/100ps
`default_nettype none
module adcc_top_tb;
    // ----------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------
    logic pclk = 1'b0; // 20 MHz system clock
    logic presetn = 1'b0; // Held low for three cycles
    logic psel = 1'b0; // APB select
    logic penable = 1'b0; // APB enable
    logic pwrite = 1'b0; // APB direction
    logic [7:0] paddr = 8'h0; // APB address
    logic [31:0] pwdata = 32'h0; // APB write data
    logic [11:0] conv_sample = 12'h0; // Converter word, held per run
    logic [31:0] prdata; // Read data
    logic pready, pslverr; // Handshake and error
    logic converter_enable, bandgap_enable, temp_sensor_enable;
    logic conv_done_irq; // Done request level
    logic [7:0] ext_analog_inputs; // Channel switches
    logic [4:0] int_source_onehot; // Source switches
    logic [1:0] reference_sel; // Reference choice
    int n_errors = 0; // Mismatches
    int n_tests = 0; // Comparisons
    logic [31:0] rd; // Last read word
    logic err; // Last error response
    logic [11:0] smp = 12'h0; // Last converted sample
    logic jst = 1'b0; // Justify of that sample
    logic [2:0] dv = 3'h0; // Divide code of the next run
    int cyc = 0; // Edge count for the run length check

    // Free-running clock, 50 ns period
    always #25 pclk = ~pclk;

    // Edge counter read by the conversion length check
    always @(posedge pclk) cyc <= cyc + 1;

    adcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_sample(conv_sample),
        .converter_enable(converter_enable),
        .ext_analog_inputs(ext_analog_inputs),
        .int_source_onehot(int_source_onehot),
        .reference_sel(reference_sel), .bandgap_enable(bandgap_enable),
        .temp_sensor_enable(temp_sensor_enable),
        .conv_done_irq(conv_done_irq));

    // ----------------------------------------------------------
    // Expectations and bus tasks
    // ----------------------------------------------------------
    function automatic logic [7:0] hi(input logic j, input logic [11:0] s);
        return j ? {4'h0, s[11:8]} : s[11:4];
    endfunction : hi

    function automatic logic [7:0] lo(input logic j, input logic [11:0] s);
        return j ? s[7:0] : {s[3:0], 4'h0};
    endfunction : lo

    // Internal sources one-hot; every external code lands on bit 4
    function automatic logic [4:0] src_exp(input logic [2:0] c);
        case (c)
            3'h1: return 5'h01;
            3'h2: return 5'h02;
            3'h3: return 5'h04;
            3'h4: return 5'h08;
            default: return 5'h10;
        endcase
    endfunction : src_exp

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask : check

    // One transfer; held until pready is sampled high, bounded wait
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg_%h", a), rd, e);
    endtask : rdc

    // Outputs are registered one cycle after the control write
    task automatic settle;
        repeat (2) @(posedge pclk);
    endtask : settle

    // Full conversion: rise, fall, busy, refused restart, poll, bytes
    task automatic conv(input logic j, input logic [3:0] ch,
        input logic [11:0] s);
        int n;
        int t0;
        int dt;
        conv_sample <= s;
        wr(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b101, j, ch});
        rdc(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b101, j, ch});
        wr(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b001, j, ch});
        t0 = cyc;
        apb(1'b0, adcc_pkg::ADDR_CTRL0, 32'h0);
        check("busy_set", 32'(rd[adcc_pkg::BUSY_BIT]), 32'h1);
        // Second pulse while busy; a restart would stretch the run
        wr(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b101, j, ch});
        wr(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b001, j, ch});
        n = 0;
        do begin
            apb(1'b0, adcc_pkg::ADDR_CTRL0, 32'h0);
            n++;
        end while (rd[adcc_pkg::BUSY_BIT] !== 1'b0 && n < 100);
        check("busy_clr", 32'(rd[adcc_pkg::BUSY_BIT]), 32'h0);
        // Four edges per transfer: busy clears 2 to 5 edges past the ticks
        dt = cyc - t0 - (int'(adcc_pkg::CONV_TICKS) << dv);
        check("conv_len", 32'(dt >= 2 && dt <= 5), 32'h1);
        rdc(adcc_pkg::ADDR_RES_HIGH, 32'(hi(j, s)));
        rdc(adcc_pkg::ADDR_RES_LOW, 32'(lo(j, s)));
        smp = s;
        jst = j;
    endtask : conv

    task automatic final_report;
        $display("Checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------------------------
    // Watchdog: whole run needs under two thousand cycles
    // ----------------------------------------------------------
    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        final_report();
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        int i;
        logic j;
        logic [11:0] s;
        void'($urandom(32'h2479_a28b));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and fixed reference pair
        rdc(adcc_pkg::ADDR_CTRL0, 32'h0);
        rdc(adcc_pkg::ADDR_CTRL1, 32'h0);
        rdc(adcc_pkg::ADDR_TSENS, 32'h2);
        rdc(adcc_pkg::ADDR_BGAP, 32'h0);
        check("src_rst", 32'(int_source_onehot), 32'h10);
        rdc(adcc_pkg::ADDR_REFT_HIGH,
            32'(adcc_pkg::REFT_VALUE[11:4]));
        rdc(adcc_pkg::ADDR_REFT_LOW,
            {24'h0, adcc_pkg::REFT_VALUE[3:0], 4'h0});
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped", 32'(err), 32'h1);
        // Every channel code, connecting and floating
        for (i = 0; i < 16; i++) begin
            wr(adcc_pkg::ADDR_CTRL0, 32'(i));
            settle();
            check("chan", 32'(ext_analog_inputs),
                i < 8 ? 32'(1 << i) : 32'h0);
        end
        // Every legal source code, then the refused one; channel parked
        for (i = 0; i < 7; i++) begin
            wr(adcc_pkg::ADDR_CTRL1, {24'h0, i[2:0], i[1:0], 3'h0});
            settle();
            check("src", 32'(int_source_onehot),
                32'(src_exp(i[2:0])));
            check("ref", 32'(reference_sel), 32'(i[1:0]));
        end
        wr(adcc_pkg::ADDR_CTRL1, 32'hF5);
        rdc(adcc_pkg::ADDR_CTRL1, 32'hD5);
        wr(adcc_pkg::ADDR_TSENS, 32'h3);
        wr(adcc_pkg::ADDR_BGAP, 32'h1);
        settle();
        check("temp_sensor_enable", 32'(temp_sensor_enable), 32'h1);
        check("bgen", 32'(bandgap_enable), 32'h1);
        // Busy cannot be written
        wr(adcc_pkg::ADDR_CTRL0, 32'h60);
        rdc(adcc_pkg::ADDR_CTRL0, 32'h20);
        settle();
        check("enable", 32'(converter_enable), 32'h1);
        wr(adcc_pkg::ADDR_IRQ, 32'h2);
        // Conversions: all-ones corners at /8, then random; source first
        for (i = 0; i < 8; i++) begin
            j = (i < 2) ? i[0] : 1'($urandom);
            s = (i < 2) ? 12'hFFF : 12'($urandom);
            dv = (i < 2) ? 3'h3 : 3'($urandom % 4);
            wr(adcc_pkg::ADDR_CTRL1, 32'(dv));
            conv(j, 4'($urandom % 8), s);
        end
        rdc(adcc_pkg::ADDR_IRQ, 32'h3);
        check("irq", 32'(conv_done_irq), 32'h1);
        wr(adcc_pkg::ADDR_IRQ, 32'h3);
        settle();
        rdc(adcc_pkg::ADDR_IRQ, 32'h2);
        check("irq_clr", 32'(conv_done_irq), 32'h0);
        // Result bytes ignore writes
        wr(adcc_pkg::ADDR_RES_LOW, 32'hFF);
        rdc(adcc_pkg::ADDR_RES_LOW, 32'(lo(jst, smp)));
        // Start pulse while disabled changes nothing
        conv_sample <= ~smp;
        wr(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b100, jst, 4'h0});
        wr(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b000, jst, 4'h0});
        settle();
        rdc(adcc_pkg::ADDR_CTRL0, {24'h0, 3'b000, jst, 4'h0});
        check("enable_off", 32'(converter_enable), 32'h0);
        rdc(adcc_pkg::ADDR_RES_HIGH, 32'(hi(jst, smp)));
        rdc(adcc_pkg::ADDR_RES_LOW, 32'(lo(jst, smp)));
        final_report();
    end
endmodule : adcc_top_tb
`default_nettype wire
